// file: src/exc_map_pkg.sv
package exc_map_pkg;

    localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;
    localparam logic [31:0] GEN_OFFSET = 32'h0000_0100;
    localparam logic [31:0] TLB_MISS_OFFSET = 32'h0000_0400;
    localparam logic [31:0] INT_OFFSET = 32'h0000_0600;
    localparam logic [31:0] BASE_AT_RESET = 32'h0000_0000;

    localparam logic [11:0] CODE_POWER_ON = 12'h000;
    localparam logic [11:0] CODE_MANUAL = 12'h020;
    localparam logic [11:0] CODE_USER_BREAK = 12'h1e0;
    localparam logic [11:0] CODE_NMI = 12'h1c0;
    localparam logic [11:0] CODE_IRL_BASE = 12'h200;
    localparam logic [11:0] CODE_PERIPH_BASE = 12'h400;
    localparam logic [11:0] CODE_DMA_BASE = 12'h640;
    localparam logic [11:0] CODE_FIFO_BASE = 12'h700;
    localparam logic [11:0] CODE_STEP = 12'h020;
    localparam logic [11:0] CODE_NONE = 12'h000;

    localparam int NUM_PERIPH = 18;
    localparam int NUM_DMA = 5;
    localparam int NUM_FIFO = 4;
    localparam int NUM_SRC = NUM_PERIPH + NUM_DMA + NUM_FIFO;
    localparam int PRIO_W = 5;

    localparam logic [3:0] IRL_NONE = 4'hf;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam int ST_BLOCK = 28;
    localparam int ST_PRIV = 30;
    localparam int ST_BANK = 29;
    localparam int ST_FPU_OFF = 15;
    localparam int ST_IMASK_LO = 4;
    localparam logic [31:0] ST_RESET = 32'h7000_00f0;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] pc;
    } cpu_ctx_s;

    typedef struct packed {
        logic take;
        logic is_reset;
        logic is_int;
        logic [11:0] code;
        logic [31:0] target;
    } dispatch_s;

endpackage

// file: src/int_arbiter.sv
`timescale 1ns/1ps
module int_arbiter
    import exc_map_pkg::*;
#(
    parameter int N = NUM_SRC
)
(
    // Requests and programmable orders
    input wire logic [N-1:0] req,
    input wire logic [N*PRIO_W-1:0] order,
    // Winner
    output logic found,
    output logic [$clog2(N)-1:0] win
);

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [PRIO_W-1:0] best;
        best = '1;
        found = 1'b0;
        win = '0;
        for (int i = 0; i < N; i++)
        begin
            if (req[i] && (!found || order[i*PRIO_W +: PRIO_W] < best))
            begin
                found = 1'b1;
                best = order[i*PRIO_W +: PRIO_W];
                win = ($clog2(N))'(i);
            end
        end
    end

endmodule

// file: src/exception_vector_code_map.sv
// Notes on behaviour
// - Timer, clock, serial, watchdog, refresh, debug and GPIO interrupts give codes 0x400-0x620.
// - DMA end 0x640-0x6a0, DMA address error 0x6c0, FIFO serial 0x700-0x760.
// - Choose by lowest order number only, ties to the lowest source index; NMI wins over every other interrupt.
// - Every reset jumps to 0xa0000000 regardless of the vector base.
// - Other events except a debug-vectored user break go to vector base plus offset; interrupts use offset 0x600.
// - Resets and general exceptions write the exception code, interrupts the interrupt code.
// - Level pins 0xb-0xe give codes 0x360-0x3c0, from four level pins.
// - With debug vector enable set, a user break loads the pc from the debug base.
// - Otherwise a user break jumps to vector base plus 0x100.
// - Order among external and peripheral interrupts is set by software.
// - Taking a non-reset event updates saved status, saved pc, code, status word and pc.
// - Power-on reset stores code 0x000, manual reset 0x020.
`timescale 1ns/1ps
module exception_vector_code_map
    import exc_map_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reset requests
    input wire logic power_on_req,
    input wire logic manual_req,
    // General exception from pipeline
    input wire logic gen_exc_req,
    input wire logic [11:0] gen_exc_code,
    input wire logic gen_exc_tlb_miss,
    input wire logic user_break_req,
    // Interrupt sources
    input wire logic nmi_req,
    input wire logic [3:0] irq_level_pins,
    input wire logic [NUM_SRC-1:0] periph_irq,
    input wire logic [NUM_SRC*PRIO_W-1:0] periph_order,
    input wire logic [PRIO_W-1:0] irl_order,
    // Pipeline context
    input wire logic insn_complete,
    input wire cpu_ctx_s cur_ctx,
    input wire logic [31:0] next_pc,
    // Control
    input wire logic [31:0] vector_base,
    input wire logic [31:0] debug_vector_base,
    input wire logic debug_vector_enable,
    // Results
    output logic redirect,
    output logic [31:0] pc_out,
    output logic [31:0] status_word,
    output logic [31:0] saved_status,
    output logic [31:0] saved_pc,
    output logic [11:0] exception_event_code,
    output logic [11:0] interrupt_event_code
);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] irl_meta_reg, irl_sync_reg;
    logic por_meta_reg, por_sync_reg, man_meta_reg, man_sync_reg, nmi_meta_reg, nmi_sync_reg;
    logic [NUM_SRC-1:0] pirq_meta_reg, pirq_sync_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irl_meta_reg <= IRL_NONE;
            irl_sync_reg <= IRL_NONE;
            por_meta_reg <= 1'b0;
            por_sync_reg <= 1'b0;
            man_meta_reg <= 1'b0;
            man_sync_reg <= 1'b0;
            nmi_meta_reg <= 1'b0;
            nmi_sync_reg <= 1'b0;
            pirq_meta_reg <= '0;
            pirq_sync_reg <= '0;
        end
        else
        begin
            irl_meta_reg <= irq_level_pins;
            irl_sync_reg <= irl_meta_reg;
            por_meta_reg <= power_on_req;
            por_sync_reg <= por_meta_reg;
            man_meta_reg <= manual_req;
            man_sync_reg <= man_meta_reg;
            nmi_meta_reg <= nmi_req;
            nmi_sync_reg <= nmi_meta_reg;
            pirq_meta_reg <= periph_irq;
            pirq_sync_reg <= pirq_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Peripheral and level interrupt arbitration
    localparam int NW = $clog2(NUM_SRC + 1);
    logic [NUM_SRC:0] all_req;
    logic [(NUM_SRC+1)*PRIO_W-1:0] all_order;
    logic int_found;
    logic [NW-1:0] int_win;
    logic irl_active;
    logic [11:0] src_code [NUM_SRC+1];

    assign irl_active = (irl_sync_reg != IRL_NONE);
    assign all_req = {irl_active, pirq_sync_reg};
    assign all_order = {irl_order, periph_order};

    int_arbiter #(.N(NUM_SRC + 1)) u_arb
    (
        .req(all_req),
        .order(all_order),
        .found(int_found),
        .win(int_win)
    );

    // Code table per source
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_code
            if (g < NUM_PERIPH)
            begin : g_p
                assign src_code[g] = CODE_PERIPH_BASE + 12'(g) * CODE_STEP;
            end
            else if (g < NUM_PERIPH + NUM_DMA)
            begin : g_d
                assign src_code[g] = CODE_DMA_BASE + 12'(g - NUM_PERIPH) * CODE_STEP;
            end
            else
            begin : g_f
                assign src_code[g] = CODE_FIFO_BASE
                    + 12'(g - NUM_PERIPH - NUM_DMA) * CODE_STEP;
            end
        end
    endgenerate
    assign src_code[NUM_SRC] = CODE_IRL_BASE + 12'({4'h0, irl_sync_reg}) * CODE_STEP;

    ////////////////////////////////////////////////////////////////
    // Dispatch selection
    dispatch_s disp;
    logic int_ok;

    // Interrupts wait for a boundary with blocking clear
    assign int_ok = insn_complete && !cur_ctx.status[ST_BLOCK];

    always_comb
    begin
        disp = '0;
        if (por_sync_reg || man_sync_reg)
        begin
            disp.take = 1'b1;
            disp.is_reset = 1'b1;
            disp.code = por_sync_reg ? CODE_POWER_ON : CODE_MANUAL;
            disp.target = RESET_VECTOR;
        end
        else if (user_break_req)
        begin
            disp.take = 1'b1;
            disp.code = CODE_USER_BREAK;
            if (debug_vector_enable)
            begin
                disp.target = debug_vector_base;
            end
            else
            begin
                disp.target = vector_base + GEN_OFFSET;
            end
        end
        else if (gen_exc_req)
        begin
            disp.take = 1'b1;
            disp.code = gen_exc_code;
            disp.target = vector_base + (gen_exc_tlb_miss ? TLB_MISS_OFFSET : GEN_OFFSET);
        end
        else if (int_ok && (nmi_sync_reg || int_found))
        begin
            disp.take = 1'b1;
            disp.is_int = 1'b1;
            disp.code = nmi_sync_reg ? CODE_NMI : src_code[int_win];
            disp.target = vector_base + INT_OFFSET;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Redirect pulse and program counter
    logic redirect_reg, redirect_next;
    logic [31:0] pc_reg, pc_next;

    always_comb
    begin
        redirect_next = disp.take;
        pc_next = pc_reg;
        if (disp.take)
        begin
            pc_next = disp.target;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            redirect_reg <= 1'b0;
            pc_reg <= RESET_VECTOR;
        end
        else
        begin
            redirect_reg <= redirect_next;
            pc_reg <= pc_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status word
    logic [31:0] stat_reg, stat_next;

    always_comb
    begin
        stat_next = stat_reg;
        if (disp.take && disp.is_reset)
        begin
            stat_next = ST_RESET;
        end
        else if (disp.take)
        begin
            stat_next = cur_ctx.status;
            stat_next[ST_BLOCK] = 1'b1;
            stat_next[ST_PRIV] = 1'b1;
            stat_next[ST_BANK] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stat_reg <= ST_RESET;
        end
        else
        begin
            stat_reg <= stat_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Saved context, untouched by reset events
    logic [31:0] saved_stat_reg, saved_stat_next, saved_pc_reg, saved_pc_next;

    always_comb
    begin
        saved_stat_next = saved_stat_reg;
        saved_pc_next = saved_pc_reg;
        if (disp.take && !disp.is_reset)
        begin
            saved_stat_next = cur_ctx.status;
            saved_pc_next = disp.is_int ? next_pc : cur_ctx.pc;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            saved_stat_reg <= '0;
            saved_pc_reg <= '0;
        end
        else
        begin
            saved_stat_reg <= saved_stat_next;
            saved_pc_reg <= saved_pc_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Event code registers
    logic [11:0] exp_reg, exp_next, int_reg, int_next;

    always_comb
    begin
        exp_next = exp_reg;
        int_next = int_reg;
        if (disp.take && disp.is_int)
        begin
            int_next = disp.code;
        end
        else if (disp.take)
        begin
            exp_next = disp.code;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            exp_reg <= CODE_POWER_ON;
            int_reg <= CODE_NONE;
        end
        else
        begin
            exp_reg <= exp_next;
            int_reg <= int_next;
        end
    end

    assign redirect = redirect_reg;
    assign pc_out = pc_reg;
    assign status_word = stat_reg;
    assign saved_status = saved_stat_reg;
    assign saved_pc = saved_pc_reg;
    assign exception_event_code = exp_reg;
    assign interrupt_event_code = int_reg;

endmodule

// file: tb/exc_map_checker.sv
`timescale 1ns/1ps
module exc_map_checker
    import exc_map_pkg::*;
(
    // Requests and context
    input logic clk,
    input logic rst,
    input logic power_on_req,
    input logic manual_req,
    input logic gen_exc_req,
    input logic [11:0] gen_exc_code,
    input logic gen_exc_tlb_miss,
    input logic user_break_req,
    input logic nmi_req,
    input logic [3:0] irq_level_pins,
    input logic [NUM_SRC-1:0] periph_irq,
    input logic insn_complete,
    input cpu_ctx_s cur_ctx,
    input logic [31:0] next_pc,
    input logic [31:0] vector_base,
    input logic [31:0] debug_vector_base,
    input logic debug_vector_enable,
    // Results
    input logic redirect,
    input logic [31:0] pc_out,
    input logic [31:0] status_word,
    input logic [31:0] saved_status,
    input logic [31:0] saved_pc,
    input logic [11:0] exception_event_code,
    input logic [11:0] interrupt_event_code
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic calm;
    assign calm = !power_on_req && !manual_req && !nmi_req && !gen_exc_req && !user_break_req
        && insn_complete && !cur_ctx.status[ST_BLOCK];
    sequence no_reset;
        (!power_on_req && !manual_req)[*3];
    endsequence
    sequence int_taken;
        redirect && pc_out == $past(vector_base) + INT_OFFSET;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_PON: assert property (power_on_req[*3] |=> redirect
        && pc_out == RESET_VECTOR && exception_event_code == CODE_POWER_ON)
        else $error("power-on reset entry wrong");
    AST_MAN: assert property ((manual_req && !power_on_req)[*3] |=> redirect
        && pc_out == RESET_VECTOR && exception_event_code == CODE_MANUAL)
        else $error("manual reset entry wrong");
    AST_GEN: assert property (no_reset ##0 (gen_exc_req && !user_break_req) |=>
        redirect && exception_event_code == $past(gen_exc_code)
        && pc_out == $past(vector_base) + ($past(gen_exc_tlb_miss) ? TLB_MISS_OFFSET : GEN_OFFSET)
        && saved_pc == $past(cur_ctx.pc) && saved_status == $past(cur_ctx.status)
        && status_word[30:28] == 3'h7) else $error("general exception entry wrong");
    AST_BREAK: assert property (no_reset ##0 user_break_req |=> redirect
        && exception_event_code == CODE_USER_BREAK && pc_out == ($past(debug_vector_enable)
        ? $past(debug_vector_base) : $past(vector_base) + GEN_OFFSET))
        else $error("user break entry wrong");
    AST_INT: assert property ((calm && $onehot(periph_irq) && $stable(periph_irq)
        && irq_level_pins == IRL_NONE)[*4] |=> redirect && saved_pc == $past(next_pc)
        && pc_out == $past(vector_base) + INT_OFFSET) else $error("interrupt entry wrong");
    AST_REFUSE: assert property (int_taken |->
        $past(insn_complete) && !$past(cur_ctx.status[ST_BLOCK]))
        else $error("interrupt taken while refused");
    AST_INT_EXC: assert property (int_taken |-> $stable(exception_event_code))
        else $error("interrupt touched exception code");
    AST_IRL: assert property ((calm && periph_irq == '0 && $stable(irq_level_pins)
        && irq_level_pins inside {[4'hb:4'he]})[*4] |=> redirect
        && interrupt_event_code == 12'h360 + {3'h0, $past(irq_level_pins) - 4'hb, 5'h00})
        else $error("level code wrong");
endmodule
bind exception_vector_code_map exc_map_checker i_exc_map_checker (.clk, .rst, .power_on_req,
    .manual_req, .gen_exc_req, .gen_exc_code, .gen_exc_tlb_miss, .user_break_req, .nmi_req,
    .irq_level_pins, .periph_irq, .insn_complete, .cur_ctx, .next_pc, .vector_base,
    .debug_vector_base, .debug_vector_enable, .redirect, .pc_out, .status_word, .saved_status,
    .saved_pc, .exception_event_code, .interrupt_event_code);

// file: tb/pipe_model.sv
`timescale 1ns/1ps
module pipe_model
    import exc_map_pkg::*;
(
    // Core side
    input logic clk,
    input logic rst,
    input logic stall,
    input logic blocked,
    output logic insn_complete,
    output cpu_ctx_s cur_ctx,
    output logic [31:0] next_pc
);
    logic [31:0] pc_reg;
    always_ff @(posedge clk)
        pc_reg <= rst ? 32'h0c00_0000 : stall ? pc_reg : pc_reg + 32'h2;
    // Boundary only when not stalled
    assign insn_complete = !stall;
    assign cur_ctx = '{status: 32'h4000_00f0 | {3'h0, blocked, 28'h0}, pc: pc_reg};
    assign next_pc = pc_reg + 32'h2;
endmodule

// file: tb/exception_vector_code_map_bench.sv
`timescale 1ns/1ps
module exception_vector_code_map_bench
    import exc_map_pkg::*;
;
    logic clk = '0, rst = 1'h1, stall = '0, power_on_req = '0, manual_req = '0, nmi_req = '0;
    logic gen_exc_req = '0, gen_exc_tlb_miss = '0, user_break_req = '0, debug_vector_enable = '0;
    logic [11:0] gen_exc_code = 12'h0e0, exception_event_code, interrupt_event_code;
    logic [3:0] irq_level_pins = IRL_NONE;
    logic [NUM_SRC-1:0] periph_irq = '0;
    logic [NUM_SRC*PRIO_W-1:0] periph_order = '0;
    logic [PRIO_W-1:0] irl_order = '0;
    logic [31:0] vector_base = 32'h1000, debug_vector_base = 32'h8000, t;
    logic [31:0] next_pc, pc_out, status_word, saved_status, saved_pc;
    logic insn_complete, redirect;
    logic blocked = '0;
    cpu_ctx_s cur_ctx;
    int num_errors = 0, total_checks = 0, seed = 69, a, b;
    exception_vector_code_map i_exception_vector_code_map (.clk, .rst, .power_on_req,
        .manual_req, .gen_exc_req, .gen_exc_code, .gen_exc_tlb_miss, .user_break_req, .nmi_req,
        .irq_level_pins, .periph_irq, .periph_order, .irl_order, .insn_complete, .cur_ctx,
        .next_pc, .vector_base, .debug_vector_base, .debug_vector_enable, .redirect, .pc_out,
        .status_word, .saved_status, .saved_pc, .exception_event_code, .interrupt_event_code);
    pipe_model i_pipe_model (.clk, .rst, .stall, .blocked, .insn_complete, .cur_ctx, .next_pc);
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Wait for entry, check, hold briefly, release all
    task automatic take(logic [31:0] pc, logic [11:0] code, logic irq);
        int n;
        n = 0;
        while (redirect !== 1'h1 && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("redirect", 1, redirect);
        chk("pc_out", pc, pc_out);
        chk("code", code, irq ? interrupt_event_code : exception_event_code);
        repeat (2) @(posedge clk);
        #1;
        {power_on_req, manual_req, gen_exc_req, user_break_req, nmi_req, periph_irq} = '0;
        irq_level_pins = IRL_NONE;
        repeat (5) @(posedge clk);
        #1;
    endtask
    function automatic logic [11:0] code_of(int i);
        if (i < 18) return 12'h400 + 12'(i * 32);
        if (i < 23) return 12'h640 + 12'((i - 18) * 32);
        return 12'h700 + 12'((i - 23) * 32);
    endfunction
    function automatic logic [11:0] pick(int x, int y);
        return periph_order[y*PRIO_W +: PRIO_W] < periph_order[x*PRIO_W +: PRIO_W]
            ? code_of(y) : code_of(x);
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = '0;
        chk("reset_pc", RESET_VECTOR, pc_out);
        manual_req = 1'h1;
        take(RESET_VECTOR, CODE_MANUAL, '0);
        power_on_req = 1'h1;
        take(RESET_VECTOR, CODE_POWER_ON, '0);
        $display("test reset done");
        repeat (6)
        begin
            vector_base = 32'($random(seed)) & 32'h7fff_f000;
            gen_exc_code = 12'($random(seed)) & 12'h7e0;
            gen_exc_tlb_miss = 1'($random(seed));
            gen_exc_req = 1'h1;
            periph_irq = '1;
            t = vector_base + (gen_exc_tlb_miss ? TLB_MISS_OFFSET : GEN_OFFSET);
            repeat (3) @(posedge clk);
            #1;
            take(t, gen_exc_code, '0);
        end
        for (int i = 0; i < 2; i++)
        begin
            debug_vector_enable = i[0];
            user_break_req = 1'h1;
            gen_exc_req = 1'h1;
            t = i ? debug_vector_base : vector_base + GEN_OFFSET;
            take(t, CODE_USER_BREAK, '0);
        end
        $display("test exceptions done");
        for (int i = 0; i < NUM_SRC; i++)
        begin
            periph_irq[i] = 1'h1;
            take(vector_base + INT_OFFSET, code_of(i), 1'h1);
        end
        for (int l = 11; l < 15; l++)
        begin
            irq_level_pins = l[3:0];
            take(vector_base + INT_OFFSET, 12'h360 + 12'((l - 11) * 32), 1'h1);
        end
        $display("test codes done");
        repeat (8)
        begin
            for (int k = 0; k < NUM_SRC; k++)
                periph_order[k*PRIO_W +: PRIO_W] = 5'(1 + {$random(seed)} % 30);
            irl_order = ($random(seed) & 1) ? 5'h00 : 5'h1f;
            a = {$random(seed)} % 13;
            b = 13 + {$random(seed)} % 14;
            periph_irq[a] = 1'h1;
            periph_irq[b] = 1'h1;
            irq_level_pins = 4'hc;
            t = irl_order == 5'h00 ? 32'h380 : 32'(pick(a, b));
            take(vector_base + INT_OFFSET, t[11:0], 1'h1);
        end
        nmi_req = 1'h1;
        periph_irq[3] = 1'h1;
        irq_level_pins = 4'hb;
        take(vector_base + INT_OFFSET, CODE_NMI, 1'h1);
        $display("test priority done");
        stall = 1'h1;
        periph_irq[5] = 1'h1;
        repeat (6) @(posedge clk);
        #1;
        chk("refused", '0, redirect);
        stall = '0;
        blocked = 1'h1;
        repeat (6) @(posedge clk);
        #1;
        chk("blocked", '0, redirect);
        blocked = '0;
        take(vector_base + INT_OFFSET, 12'h4a0, 1'h1);
        $display("test boundary done");
        print_verdict;
    end
    initial
    begin
        #20000;
        num_errors++;
        print_verdict;
    end
endmodule
